// file: bench/ddrbk_props.sv
// Purpose: Assertions on the command pins between controller and device
// Assumes: One mclk domain, rst synchronous active high
// Notes:   Cycle figures follow the package timing counts
`timescale 1ns/1ps
`default_nettype none
module ddrbk_props #(
	parameter int NBANK = 8,
	parameter int BA_W  = 3
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Command pins
	input  wire logic             cke,
	input  wire logic             cs_n,
	input  wire logic             ras_n,
	input  wire logic             cas_n,
	input  wire logic             we_n,
	input  wire logic [BA_W-1:0]  ba,
	input  wire logic             a10,
	// Device status
	input  wire logic             cmd_err,
	input  wire logic             mr_wr,
	input  wire logic [BA_W-1:0]  mr_sel,
	input  wire logic [NBANK-1:0] bank_idle,
	input  wire logic             dev_busy
);
	logic       cke_q_ff;
	logic       nxt_cke_q;
	logic [3:0] cmd;
	logic       live;
	// Commands count only with clock enable high on two edges
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign live = cke && cke_q_ff;
	always_comb begin
		nxt_cke_q = rst ? 1'b0 : cke;
	end
	always_ff @(posedge mclk) begin
		cke_q_ff <= nxt_cke_q;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ************************************************************
	// Properties
	// ************************************************************
	property p_no_err; !cmd_err; endproperty
	property p_act; live && cmd == ddrbk_pkg::CMD_ACT |=> !bank_idle[$past(ba)]; endproperty
	property p_lmr; live && cmd == ddrbk_pkg::CMD_LMR |=> mr_wr && dev_busy && mr_sel == $past(ba); endproperty
	property p_ref;
		live && cmd == ddrbk_pkg::CMD_REF |=> (dev_busy && (cs_n || cmd == ddrbk_pkg::CMD_NOP)) [*5];
	endproperty
	property p_rdap;
		live && cmd == ddrbk_pkg::CMD_RD && a10 |=> !bank_idle[$past(ba)] ##1 !bank_idle[$past(ba, 2)];
	endproperty
	property p_wrap;
		live && cmd == ddrbk_pkg::CMD_WR && a10 |=> !bank_idle[$past(ba)] ##1 !bank_idle[$past(ba, 2)]
			##1 !bank_idle[$past(ba, 3)];
	endproperty
	property p_gap;
		live && (cmd == ddrbk_pkg::CMD_RD || cmd == ddrbk_pkg::CMD_WR) |=> !(cmd inside {4'h5, 4'h4});
	endproperty
	property p_pd; !cke |-> cs_n || cmd == ddrbk_pkg::CMD_NOP; endproperty
	// Controller only issues legal commands, so the device never objects
	a_no_err: assert property (p_no_err) else $error("device flagged a controller command");
	a_act: assert property (p_act) else $error("activated bank still idle");
	a_lmr: assert property (p_lmr) else $error("mode load not taken");
	a_ref: assert property (p_ref) else $error("refresh lockout broken");
	a_rdap: assert property (p_rdap) else $error("read auto precharge left early");
	a_wrap: assert property (p_wrap) else $error("write auto precharge left early");
	a_gap: assert property (p_gap) else $error("burst interrupted");
	a_pd: assert property (p_pd) else $error("command during power-down");
	c_ref: cover property (live && cmd == ddrbk_pkg::CMD_REF);
	c_lmr: cover property (live && cmd == ddrbk_pkg::CMD_LMR);
	c_rdap: cover property (live && cmd == ddrbk_pkg::CMD_RD && a10);
	c_pd: cover property (!cke);
endmodule
`default_nettype wire

// file: bench/ddrbk_tb.sv
// Purpose: Self-checking bench, controller and device face to face
// Assumes: 40 MHz mclk; a second device takes rule-breaking commands
// Notes:   Bank map expectation kept by a small open-row model
`timescale 1ns/1ps
`default_nettype none
module ddrbk_tb;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic                 req_valid = 1'b0;
	ddrbk_pkg::ddrbk_op_e req_op = ddrbk_pkg::OP_ACT;
	logic [2:0]           req_bank = 3'h0;
	logic                 req_ap = 1'b0;
	logic                 pd_req = 1'b0;
	logic                 req_ready, pd_active, cmd_err, mr_wr, dev_busy, dev_pd, err_b, pd_b, sr_b;
	logic [2:0]           mr_sel, sel_b;
	logic [7:0]           bank_idle, idle_b;
	logic [7:0]           open_m = 8'h00;
	int                   n_fail = 0;
	int                   compares = 0;
	ddrbk_if if_a ();
	ddrbk_if if_b ();
	ddrbk_ctrl ddrbk_ctrl_i (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_bank(req_bank),
		.req_ap(req_ap), .req_ready(req_ready), .pd_req(pd_req), .pd_active(pd_active), .pins(if_a.ctrl));
	ddrbk_dev ddrbk_dev_i (.mclk(mclk), .rst(rst), .pins(if_a.dev), .cmd_err(cmd_err), .mr_wr(mr_wr),
		.mr_sel(mr_sel), .bank_idle(bank_idle), .sr_active(), .pd_active(dev_pd), .dev_busy(dev_busy));
	// Second device sees only the bench driver, so faults stay off the checked pair
	ddrbk_dev ddrbk_dev_b_i (.mclk(mclk), .rst(rst), .pins(if_b.dev), .cmd_err(err_b), .mr_wr(),
		.mr_sel(sel_b), .bank_idle(idle_b), .sr_active(sr_b), .pd_active(pd_b), .dev_busy());
	ddrbk_props ddrbk_props_i (.mclk(mclk), .rst(rst), .cke(if_a.cke), .cs_n(if_a.cs_n), .ras_n(if_a.ras_n),
		.cas_n(if_a.cas_n), .we_n(if_a.we_n), .ba(if_a.ba), .a10(if_a.a10), .cmd_err(cmd_err), .mr_wr(mr_wr),
		.mr_sel(mr_sel), .bank_idle(bank_idle), .dev_busy(dev_busy));
	always #12.5 mclk = ~mclk;
	// Open-row model of one request
	function automatic logic [7:0] next_open(input logic [7:0] o, input ddrbk_pkg::ddrbk_op_e op,
		input logic [2:0] b, input logic ap);
		case (op)
			ddrbk_pkg::OP_ACT: return o | (8'h01 << b);
			ddrbk_pkg::OP_PRE: return o & ~(8'h01 << b);
			ddrbk_pkg::OP_PREA: return 8'h00;
			ddrbk_pkg::OP_RD, ddrbk_pkg::OP_WR: return ap ? o & ~(8'h01 << b) : o;
			default: return o;
		endcase
	endfunction
	task automatic check(input logic ok, input string what);
		compares++;
		if (!ok) begin
			n_fail++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask
	task automatic print_verdict();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Request held until taken, then the bank map is compared once settled
	task automatic req(input ddrbk_pkg::ddrbk_op_e op, input logic [2:0] b, input logic ap);
		int i;
		@(posedge mclk);
		req_op <= op;
		req_bank <= b;
		req_ap <= ap;
		req_valid <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (req_ready !== 1'b1 && i < 200);
		req_valid <= 1'b0;
		check(i < 200, "request never taken");
		open_m = next_open(open_m, op, b, ap);
		repeat (8) @(posedge mclk);
		#1;
		check(bank_idle === ~open_m, "bank idle map");
	endtask
	// Released pins show inverted address so stale values are not trusted
	task automatic drv(input logic [3:0] c, input logic [2:0] b, input logic a);
		@(posedge mclk);
		{if_b.cs_n, if_b.ras_n, if_b.cas_n, if_b.we_n} <= c;
		if_b.ba <= b;
		if_b.a10 <= a;
	endtask
	task automatic bad(input logic [3:0] c, input logic [2:0] b, input logic a, input logic e);
		drv(c, b, a);
		drv(ddrbk_pkg::CMD_NOP, ~b, ~a);
		#1;
		check(err_b === e, "error flag");
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		$display("ERROR %0t watchdog expired", $time);
		print_verdict();
	end
	initial begin
		ddrbk_pkg::ddrbk_op_e op;
		logic [2:0] b;
		int i;
		{if_b.cke, if_b.cs_n, if_b.ras_n, if_b.cas_n, if_b.we_n, if_b.ba, if_b.a10} = 9'h1f0;
		void'($urandom(32'hde4f));
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		req(ddrbk_pkg::OP_ACT, 3'h2, 1'b0);
		req(ddrbk_pkg::OP_RD, 3'h2, 1'b0);
		req(ddrbk_pkg::OP_WR, 3'h2, 1'b0);
		req(ddrbk_pkg::OP_RD, 3'h2, 1'b1);
		req(ddrbk_pkg::OP_ACT, 3'h5, 1'b0);
		req(ddrbk_pkg::OP_WR, 3'h5, 1'b1);
		req(ddrbk_pkg::OP_ACT, 3'h7, 1'b0);
		req(ddrbk_pkg::OP_PRE, 3'h7, 1'b0);
		req(ddrbk_pkg::OP_ACT, 3'h0, 1'b0);
		req(ddrbk_pkg::OP_PREA, 3'h0, 1'b0);
		req(ddrbk_pkg::OP_REF, 3'h0, 1'b0);
		req(ddrbk_pkg::OP_LMR, 3'h3, 1'b0);
		check(mr_sel === 3'h3, "mode register select");
		@(posedge mclk);
		pd_req <= 1'b1;
		for (i = 0; i < 20 && dev_pd !== 1'b1; i++) @(posedge mclk);
		check(if_a.cke === 1'b0 && dev_pd === 1'b1, "power-down");
		// Request held on: the controller must still leave in time for refresh
		for (i = 0; i < 400 && pd_active === 1'b1; i++) @(posedge mclk);
		check(i <= ddrbk_pkg::PD_MAX_CYC, "power-down not bounded");
		@(posedge mclk);
		pd_req <= 1'b0;
		for (int k = 0; k < 40; k++) begin
			b = 3'($urandom_range(7));
			op = ddrbk_pkg::OP_ACT;
			if (open_m[b]) begin
				case ($urandom_range(2))
					0: op = ddrbk_pkg::OP_RD;
					1: op = ddrbk_pkg::OP_WR;
					default: op = ddrbk_pkg::OP_PRE;
				endcase
			end
			req(op, b, 1'($urandom_range(1)));
		end
		bad(ddrbk_pkg::CMD_RD, 3'h0, 1'b0, 1'b1);
		bad(4'h6, 3'h0, 1'b0, 1'b1);
		bad(ddrbk_pkg::CMD_ACT, 3'h1, 1'b0, 1'b0);
		bad(ddrbk_pkg::CMD_RD, 3'h1, 1'b1, 1'b0);
		bad(ddrbk_pkg::CMD_ACT, 3'h1, 1'b0, 1'b1);
		repeat (6) @(posedge mclk);
		check(idle_b === 8'hff, "auto precharge idle");
		drv(ddrbk_pkg::CMD_LMR, 3'h2, 1'b0);
		bad(ddrbk_pkg::CMD_ACT, 3'h0, 1'b0, 1'b1);
		check(sel_b === 3'h2, "mode register select");
		bad(ddrbk_pkg::CMD_ACT, 3'h3, 1'b0, 1'b0);
		bad(ddrbk_pkg::CMD_REF, 3'h0, 1'b0, 1'b1);
		drv(ddrbk_pkg::CMD_RD, 3'h3, 1'b0);
		bad(ddrbk_pkg::CMD_WR, 3'h3, 1'b0, 1'b1);
		bad(ddrbk_pkg::CMD_PRE, 3'h0, 1'b1, 1'b0);
		repeat (4) @(posedge mclk);
		check(idle_b === 8'hff, "precharge all idle");
		if_b.cke <= 1'b0;
		repeat (3) @(posedge mclk);
		check(pd_b === 1'b1, "bench power-down");
		if_b.cke <= 1'b1;
		{if_b.cs_n, if_b.ras_n, if_b.cas_n, if_b.we_n} <= ddrbk_pkg::CMD_RD;
		drv(ddrbk_pkg::CMD_NOP, 3'h5, 1'b1);
		#1;
		check(err_b === 1'b0, "wake edge unchecked");
		// Self refresh: commands stay unchecked until the exit delay is over
		drv(ddrbk_pkg::CMD_REF, 3'h0, 1'b0);
		if_b.cke <= 1'b0;
		drv(ddrbk_pkg::CMD_NOP, 3'h0, 1'b0);
		#1;
		check(sr_b === 1'b1, "self refresh entry");
		@(posedge mclk);
		if_b.cke <= 1'b1;
		bad(ddrbk_pkg::CMD_RD, 3'h0, 1'b0, 1'b0);
		repeat (3) @(posedge mclk);
		bad(ddrbk_pkg::CMD_RD, 3'h0, 1'b0, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire

// file: rtl/ddrbk_ctrl.sv
// Purpose: Memory controller end that only issues legal bank commands
// Assumes: One request at a time; user holds a request until req_ready
// Notes:   Conservative: column commands wait for the previous burst end on their own bank only
`timescale 1ns/1ps
`default_nettype none
module ddrbk_ctrl #(
	parameter int NBANK     = 8,
	parameter int BURST_LEN = 4,
	parameter int BA_W      = 3
) (
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                rst,
	// User request
	input  wire logic                req_valid,
	input  wire ddrbk_pkg::ddrbk_op_e req_op,
	input  wire logic [BA_W-1:0]     req_bank,
	input  wire logic                req_ap,
	output logic                     req_ready,
	// Power-down
	input  wire logic                pd_req,
	output logic                     pd_active,
	// Command pins
	ddrbk_if.ctrl                    pins
);
	localparam logic [7:0] BURST_CYC = 8'(BURST_LEN / 2);

	ddrbk_pkg::ddrbk_kst_e st_ff  [NBANK];
	ddrbk_pkg::ddrbk_kst_e nxt_st [NBANK];
	logic [7:0]            tmr_ff [NBANK];
	logic [7:0]            nxt_tmr[NBANK];
	logic [7:0]            gtmr_ff, nxt_gtmr;
	logic [15:0]           pdc_ff, nxt_pdc;
	logic                  pd_ff, nxt_pd;
	logic                  wake_ff, nxt_wake;
	logic [3:0]            cmd_ff, nxt_cmd;
	logic [BA_W-1:0]       ba_ff, nxt_ba;
	logic                  a10_ff, nxt_a10;
	ddrbk_pkg::ddrbk_kst_e tgt;
	logic                  all_idle, all_pre_ok, legal, issue, pd_go;

	// ************************************************************
	// Acceptance
	// ************************************************************
	// A request is taken only when the device would accept it
	always_comb begin
		all_idle   = (gtmr_ff == 8'h00);
		all_pre_ok = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			all_idle   = all_idle & (st_ff[i] == ddrbk_pkg::K_IDLE);
			all_pre_ok = all_pre_ok & (st_ff[i] inside {ddrbk_pkg::K_IDLE, ddrbk_pkg::K_OPEN});
		end
		tgt = st_ff[req_bank];
		unique case (req_op)
			ddrbk_pkg::OP_ACT:  legal = (tgt == ddrbk_pkg::K_IDLE);
			ddrbk_pkg::OP_RD, ddrbk_pkg::OP_WR: legal = (tgt == ddrbk_pkg::K_OPEN);
			ddrbk_pkg::OP_PRE:  legal = (tgt inside {ddrbk_pkg::K_IDLE, ddrbk_pkg::K_OPEN});
			ddrbk_pkg::OP_PREA: legal = all_pre_ok;
			default:            legal = all_idle;
		endcase
		// Lock-out after refresh or mode load, and through power-down
		legal     = legal & (gtmr_ff == 8'h00) & ~pd_ff & ~wake_ff;
		req_ready = legal;
		issue     = req_valid & legal;
		pd_go     = pd_req & ~req_valid & all_idle & ~pd_ff & ~wake_ff;
	end

	// ************************************************************
	// Bank view and pins
	// ************************************************************
	// Bank view, lockout timer, power-down and next pin command
	always_comb begin
		for (int i = 0; i < NBANK; i++) begin
			nxt_st[i]  = st_ff[i];
			nxt_tmr[i] = tmr_ff[i];
			if (tmr_ff[i] > 8'h01) begin
				nxt_tmr[i] = tmr_ff[i] - 8'h01;
			end else if (st_ff[i] inside {ddrbk_pkg::K_OPENING, ddrbk_pkg::K_BURST}) begin
				nxt_st[i]  = ddrbk_pkg::K_OPEN;
				nxt_tmr[i] = 8'h00;
			end else if (st_ff[i] == ddrbk_pkg::K_CLOSING) begin
				nxt_st[i]  = ddrbk_pkg::K_IDLE;
				nxt_tmr[i] = 8'h00;
			end
			if (issue && (req_op == ddrbk_pkg::OP_PREA || (req_op == ddrbk_pkg::OP_PRE && req_bank == BA_W'(i)))) begin
				nxt_st[i]  = ddrbk_pkg::K_CLOSING;
				nxt_tmr[i] = ddrbk_pkg::RP_CYC;
			end else if (issue && req_bank == BA_W'(i)) begin
				unique case (req_op)
					ddrbk_pkg::OP_ACT: begin
						nxt_st[i]  = ddrbk_pkg::K_OPENING;
						nxt_tmr[i] = ddrbk_pkg::RCD_CYC;
					end
					ddrbk_pkg::OP_RD: begin
						nxt_st[i]  = req_ap ? ddrbk_pkg::K_CLOSING : ddrbk_pkg::K_BURST;
						nxt_tmr[i] = req_ap ? BURST_CYC + ddrbk_pkg::RP_CYC : BURST_CYC;
					end
					ddrbk_pkg::OP_WR: begin
						// Write recovery folded in so a later precharge is safe
						nxt_st[i]  = req_ap ? ddrbk_pkg::K_CLOSING : ddrbk_pkg::K_BURST;
						nxt_tmr[i] = req_ap ? BURST_CYC + ddrbk_pkg::WR_CYC + ddrbk_pkg::RP_CYC
							: BURST_CYC + ddrbk_pkg::WR_CYC;
					end
					default: begin
					end
				endcase
			end
		end
		nxt_gtmr = (gtmr_ff != 8'h00) ? gtmr_ff - 8'h01 : 8'h00;
		if (issue && req_op == ddrbk_pkg::OP_REF) begin
			nxt_gtmr = ddrbk_pkg::RFC_CYC - 8'h01;
		end else if (issue && req_op == ddrbk_pkg::OP_LMR) begin
			nxt_gtmr = ddrbk_pkg::MRD_CYC - 8'h01;
		end
		// Power-down is cut short so refresh can keep its interval
		nxt_pd   = pd_ff;
		nxt_pdc  = pd_ff ? pdc_ff + 16'h0001 : 16'h0000;
		nxt_wake = 1'b0;
		if (pd_go) begin
			nxt_pd = 1'b1;
		end else if (pd_ff && (!pd_req || pdc_ff >= ddrbk_pkg::PD_MAX_CYC - 16'h0001)) begin
			nxt_pd   = 1'b0;
			nxt_wake = 1'b1;
		end
		nxt_cmd = ddrbk_pkg::CMD_NOP;
		nxt_ba  = ba_ff;
		nxt_a10 = 1'b0;
		if (issue) begin
			nxt_ba  = req_bank;
			nxt_a10 = (req_op == ddrbk_pkg::OP_PREA) | (req_ap & (req_op inside {ddrbk_pkg::OP_RD, ddrbk_pkg::OP_WR}));
			unique case (req_op)
				ddrbk_pkg::OP_ACT: nxt_cmd = ddrbk_pkg::CMD_ACT;
				ddrbk_pkg::OP_RD:  nxt_cmd = ddrbk_pkg::CMD_RD;
				ddrbk_pkg::OP_WR:  nxt_cmd = ddrbk_pkg::CMD_WR;
				ddrbk_pkg::OP_REF: nxt_cmd = ddrbk_pkg::CMD_REF;
				ddrbk_pkg::OP_LMR: nxt_cmd = ddrbk_pkg::CMD_LMR;
				default:           nxt_cmd = ddrbk_pkg::CMD_PRE;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NBANK; i++) begin
				st_ff[i]  <= ddrbk_pkg::K_IDLE;
				tmr_ff[i] <= 8'h00;
			end
			gtmr_ff <= 8'h00;
			pdc_ff  <= 16'h0000;
			pd_ff   <= 1'b0;
			wake_ff <= 1'b0;
			cmd_ff  <= ddrbk_pkg::CMD_NOP;
			ba_ff   <= '0;
			a10_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			tmr_ff  <= nxt_tmr;
			gtmr_ff <= nxt_gtmr;
			pdc_ff  <= nxt_pdc;
			pd_ff   <= nxt_pd;
			wake_ff <= nxt_wake;
			cmd_ff  <= nxt_cmd;
			ba_ff   <= nxt_ba;
			a10_ff  <= nxt_a10;
		end
	end

	assign pins.cke   = ~pd_ff;
	assign pins.cs_n  = cmd_ff[3];
	assign pins.ras_n = cmd_ff[2];
	assign pins.cas_n = cmd_ff[1];
	assign pins.we_n  = cmd_ff[0];
	assign pins.ba    = ba_ff;
	assign pins.a10   = a10_ff;
	assign pd_active  = pd_ff;
endmodule
`default_nettype wire

// file: rtl/ddrbk_dev.sv
// Purpose: Per-bank state tracking and command legality of the memory device
// Assumes: Command pins come from logic on mclk, so no synchronisers
// Notes:   Illegal commands raise cmd_err and leave the bank state unchanged
//
// Functional notes
// - Bank address picks bank or mode register
// - Self-refresh exit seen from cke level alone
// - BL4 bursts cannot be interrupted
// - No refresh work during power-down
// - Decode commands from four strobe pins
// - Idle accepts activate, refresh, load mode
// - Row active accepts read, write, precharge
// - Write after read only when burst done
// - Write burst accepts only precharge, as col_ok stays low with BL4
// - Rules apply with cke high twice, XSNR met
// - Idle after precharge time and read done
// - Row active after activate-to-column delay
// - Read/write state lasts until burst end
// - Transient bank states accept no command, except precharge to a precharging bank
// - Precharge busy until precharge time elapses
// - Auto-precharge busy until precharge met
// - Row opening until activate delay passes
// - Refresh blocks all until cycle time
// - Mode load blocks all until delay
// - Refresh and mode load need all idle
// - Precharge all needs every bank precharge-able
// - Other banks follow their own state
// - A10 selects auto precharge on column
`timescale 1ns/1ps
`default_nettype none
module ddrbk_dev #(
	parameter int NBANK     = 8,
	parameter int BURST_LEN = 4,
	parameter int BA_W      = 3
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Command pins
	ddrbk_if.dev                  pins,
	// Status to user side
	output logic                  cmd_err,
	output logic                  mr_wr,
	output logic [BA_W-1:0]       mr_sel,
	output logic [NBANK-1:0]      bank_idle,
	output logic                  sr_active,
	output logic                  pd_active,
	output logic                  dev_busy
);
	// ************************************************************
	// Constants and state
	// ************************************************************
	localparam logic [7:0] BURST_CYC = 8'(BURST_LEN / 2);
	localparam logic [7:0] COL_GAP   = 8'(BURST_LEN / 2 - 2);

	ddrbk_pkg::ddrbk_bank_e st_ff  [NBANK];
	ddrbk_pkg::ddrbk_bank_e nxt_st [NBANK];
	logic [7:0]             tmr_ff [NBANK];
	logic [7:0]             nxt_tmr[NBANK];
	logic [7:0]             gtmr_ff, nxt_gtmr;
	logic [7:0]             xs_ff, nxt_xs;
	logic                   cke_q_ff, nxt_cke_q;
	logic                   sr_ff, nxt_sr;
	logic                   pd_ff, nxt_pd;
	logic                   err_ff, nxt_err;
	logic                   mrw_ff, nxt_mrw;
	logic [BA_W-1:0]        mrs_ff, nxt_mrs;
	logic [NBANK-1:0]       idle_ff, nxt_idle;

	ddrbk_pkg::ddrbk_cmd_e  cmd;
	ddrbk_pkg::ddrbk_bank_e tgt;
	logic                   checking;
	logic                   legal;
	logic                   apply;
	logic                   all_idle;
	logic                   pre_all_ok;
	logic                   col_ok;
	logic                   gbusy;

	// ************************************************************
	// Decode and legality
	// ************************************************************
	// Command decode from the strobe pins
	always_comb begin
		if (pins.cs_n) begin
			cmd = ddrbk_pkg::C_DES;
		end else begin
			unique case ({1'b0, pins.ras_n, pins.cas_n, pins.we_n})
				ddrbk_pkg::CMD_NOP: cmd = ddrbk_pkg::C_NOP;
				ddrbk_pkg::CMD_ACT: cmd = ddrbk_pkg::C_ACT;
				ddrbk_pkg::CMD_REF: cmd = ddrbk_pkg::C_REF;
				ddrbk_pkg::CMD_LMR: cmd = ddrbk_pkg::C_LMR;
				ddrbk_pkg::CMD_RD:  cmd = ddrbk_pkg::C_RD;
				ddrbk_pkg::CMD_WR:  cmd = ddrbk_pkg::C_WR;
				ddrbk_pkg::CMD_PRE: cmd = ddrbk_pkg::C_PRE;
				default:            cmd = ddrbk_pkg::C_BAD;
			endcase
		end
	end

	// Legality of the command against the target bank and the whole device
	always_comb begin
		all_idle   = 1'b1;
		pre_all_ok = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			all_idle   = all_idle & (st_ff[i] == ddrbk_pkg::B_IDLE);
			pre_all_ok = pre_all_ok & (st_ff[i] inside {ddrbk_pkg::B_IDLE, ddrbk_pkg::B_ACTIVE,
				ddrbk_pkg::B_READ, ddrbk_pkg::B_WRITE, ddrbk_pkg::B_PRECH});
		end
		tgt    = st_ff[pins.ba];
		// BL4 leaves no gap, so a column command inside a burst is refused
		col_ok = tmr_ff[pins.ba] <= COL_GAP;
		gbusy  = (gtmr_ff != 8'h00);
		// Table applies only with cke high now and before, and XSNR met
		checking = cke_q_ff & pins.cke & ~sr_ff & (xs_ff == 8'h00);
		unique case (cmd)
			ddrbk_pkg::C_DES, ddrbk_pkg::C_NOP: legal = 1'b1;
			ddrbk_pkg::C_ACT: legal = (tgt == ddrbk_pkg::B_IDLE);
			ddrbk_pkg::C_REF, ddrbk_pkg::C_LMR: legal = all_idle;
			ddrbk_pkg::C_RD: legal = (tgt == ddrbk_pkg::B_ACTIVE)
				| ((tgt == ddrbk_pkg::B_READ) & col_ok)
				| ((tgt == ddrbk_pkg::B_WRITE) & col_ok);
			ddrbk_pkg::C_WR: legal = (tgt == ddrbk_pkg::B_ACTIVE)
				| ((tgt == ddrbk_pkg::B_WRITE) & col_ok);
			ddrbk_pkg::C_PRE: legal = pins.a10 ? pre_all_ok
				: (tgt inside {ddrbk_pkg::B_IDLE, ddrbk_pkg::B_ACTIVE, ddrbk_pkg::B_READ,
					ddrbk_pkg::B_WRITE, ddrbk_pkg::B_PRECH});
			default: legal = 1'b0;
		endcase
		// Refresh and mode load lock out every executable command
		if (gbusy && !(cmd inside {ddrbk_pkg::C_DES, ddrbk_pkg::C_NOP})) begin
			legal = 1'b0;
		end
		apply = checking & legal & !(cmd inside {ddrbk_pkg::C_DES, ddrbk_pkg::C_NOP});
	end

	// ************************************************************
	// Bank and device state
	// ************************************************************
	// Next bank states; timed states load count-1 and fall through at 1
	always_comb begin
		for (int i = 0; i < NBANK; i++) begin
			nxt_st[i]  = st_ff[i];
			nxt_tmr[i] = tmr_ff[i];
			if (tmr_ff[i] > 8'h01) begin
				nxt_tmr[i] = tmr_ff[i] - 8'h01;
			end else if (st_ff[i] inside {ddrbk_pkg::B_OPENING, ddrbk_pkg::B_READ, ddrbk_pkg::B_WRITE}) begin
				nxt_st[i]  = ddrbk_pkg::B_ACTIVE;
				nxt_tmr[i] = 8'h00;
			end else if (st_ff[i] != ddrbk_pkg::B_ACTIVE) begin
				nxt_st[i]  = ddrbk_pkg::B_IDLE;
				nxt_tmr[i] = 8'h00;
			end
			if (apply && cmd == ddrbk_pkg::C_PRE && (pins.a10 || pins.ba == BA_W'(i))) begin
				nxt_st[i]  = ddrbk_pkg::B_PRECH;
				nxt_tmr[i] = ddrbk_pkg::RP_CYC - 8'h01;
			end else if (apply && pins.ba == BA_W'(i)) begin
				unique case (cmd)
					ddrbk_pkg::C_ACT: begin
						nxt_st[i]  = ddrbk_pkg::B_OPENING;
						nxt_tmr[i] = ddrbk_pkg::RCD_CYC - 8'h01;
					end
					ddrbk_pkg::C_RD: begin
						nxt_st[i]  = pins.a10 ? ddrbk_pkg::B_RD_AP : ddrbk_pkg::B_READ;
						nxt_tmr[i] = pins.a10 ? BURST_CYC + ddrbk_pkg::RP_CYC - 8'h01 : BURST_CYC - 8'h01;
					end
					ddrbk_pkg::C_WR: begin
						nxt_st[i]  = pins.a10 ? ddrbk_pkg::B_WR_AP : ddrbk_pkg::B_WRITE;
						nxt_tmr[i] = pins.a10 ? BURST_CYC + ddrbk_pkg::WR_CYC + ddrbk_pkg::RP_CYC - 8'h01
							: BURST_CYC - 8'h01;
					end
					default: begin
					end
				endcase
			end
			// A zero count means the timed state already passed
			if (nxt_tmr[i] == 8'h00 && nxt_st[i] inside {ddrbk_pkg::B_OPENING, ddrbk_pkg::B_READ, ddrbk_pkg::B_WRITE}) begin
				nxt_st[i] = ddrbk_pkg::B_ACTIVE;
			end else if (nxt_tmr[i] == 8'h00 && nxt_st[i] inside {ddrbk_pkg::B_PRECH, ddrbk_pkg::B_RD_AP, ddrbk_pkg::B_WR_AP}) begin
				nxt_st[i] = ddrbk_pkg::B_IDLE;
			end
		end
	end

	// Device-wide timers, power modes and status
	always_comb begin
		nxt_cke_q = pins.cke;
		nxt_gtmr  = gbusy ? gtmr_ff - 8'h01 : 8'h00;
		nxt_xs    = (xs_ff != 8'h00) ? xs_ff - 8'h01 : 8'h00;
		nxt_sr    = sr_ff;
		nxt_pd    = pd_ff;
		if (apply && cmd == ddrbk_pkg::C_REF) begin
			nxt_gtmr = ddrbk_pkg::RFC_CYC - 8'h01;
		end else if (apply && cmd == ddrbk_pkg::C_LMR) begin
			nxt_gtmr = ddrbk_pkg::MRD_CYC - 8'h01;
		end
		// Self refresh entry: refresh with cke falling, all banks idle
		if (cke_q_ff && !pins.cke && cmd == ddrbk_pkg::C_REF && all_idle && !gbusy) begin
			nxt_sr = 1'b1;
		end
		// Exit needs no command edge: cke level alone ends self refresh
		if (sr_ff && pins.cke) begin
			nxt_sr = 1'b0;
			nxt_xs = ddrbk_pkg::XSNR_CYC - 8'h01;
		end
		// Power-down does no refresh; the controller bounds its length
		if (cke_q_ff && !pins.cke && (cmd inside {ddrbk_pkg::C_DES, ddrbk_pkg::C_NOP})) begin
			nxt_pd = 1'b1;
		end else if (pins.cke) begin
			nxt_pd = 1'b0;
		end
		nxt_err  = checking & ~legal;
		nxt_mrw  = apply & (cmd == ddrbk_pkg::C_LMR);
		nxt_mrs  = (apply && cmd == ddrbk_pkg::C_LMR) ? pins.ba : mrs_ff;
		for (int i = 0; i < NBANK; i++) begin
			nxt_idle[i] = (nxt_st[i] == ddrbk_pkg::B_IDLE);
		end
	end

	// Register all state
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NBANK; i++) begin
				st_ff[i]  <= ddrbk_pkg::B_IDLE;
				tmr_ff[i] <= 8'h00;
			end
			gtmr_ff  <= 8'h00;
			xs_ff    <= 8'h00;
			cke_q_ff <= 1'b0;
			sr_ff    <= 1'b0;
			pd_ff    <= 1'b0;
			err_ff   <= 1'b0;
			mrw_ff   <= 1'b0;
			mrs_ff   <= '0;
			idle_ff  <= '1;
		end else begin
			st_ff    <= nxt_st;
			tmr_ff   <= nxt_tmr;
			gtmr_ff  <= nxt_gtmr;
			xs_ff    <= nxt_xs;
			cke_q_ff <= nxt_cke_q;
			sr_ff    <= nxt_sr;
			pd_ff    <= nxt_pd;
			err_ff   <= nxt_err;
			mrw_ff   <= nxt_mrw;
			mrs_ff   <= nxt_mrs;
			idle_ff  <= nxt_idle;
		end
	end

	// Outputs straight from flops, except dev_busy decoded from the refresh/mode timer
	assign cmd_err   = err_ff;
	assign mr_wr     = mrw_ff;
	assign mr_sel    = mrs_ff;
	assign bank_idle = idle_ff;
	assign sr_active = sr_ff;
	assign pd_active = pd_ff;
	assign dev_busy  = gbusy;
endmodule
`default_nettype wire

// file: rtl/ddrbk_if.sv
// Purpose: Command pins between memory controller and bank logic
// Assumes: Both ends clocked by the same mclk
// Notes:   All command pins are active low except cke, ba and a10
`timescale 1ns/1ps
`default_nettype none
interface ddrbk_if #(parameter int BA_W = 3);
	logic            cke;
	logic            cs_n;
	logic            ras_n;
	logic            cas_n;
	logic            we_n;
	logic [BA_W-1:0] ba;
	logic            a10;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, a10);
	modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, ba, a10);
endinterface
`default_nettype wire

// file: rtl/ddrbk_pkg.sv
// Purpose: Shared constants and types for the bank command state logic
// Assumes: 40 MHz mclk, command pins driven by logic on the same clock
// Notes:   Times are in ns (or clocks where marked), cycle counts derived
package ddrbk_pkg;
	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_MHZ      = 40;
	localparam int T_RP_NS      = 15;
	localparam int T_RCD_NS     = 15;
	localparam int T_WR_NS      = 15;
	localparam int T_RFC_NS     = 128;
	localparam int T_XSNR_NS    = 138;
	localparam int T_MRD_CK     = 2;
	localparam int T_PD_MAX_NS  = 7800;
	// Least times round up to whole cycles
	localparam logic [7:0]  RP_CYC     = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  RCD_CYC    = 8'((T_RCD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  WR_CYC     = 8'((T_WR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  RFC_CYC    = 8'((T_RFC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  XSNR_CYC   = 8'((T_XSNR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  MRD_CYC    = 8'(T_MRD_CK);
	// Longest time rounds down
	localparam logic [15:0] PD_MAX_CYC = 16'((T_PD_MAX_NS * CLK_MHZ) / 1000);

	// ************************************************************
	// Command codes {cs_n, ras_n, cas_n, we_n}
	// ************************************************************
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;

	// Decoded command
	typedef enum logic [8:0] {
		C_DES = 9'h001, C_NOP = 9'h002, C_ACT = 9'h004, C_REF = 9'h008, C_LMR = 9'h010,
		C_RD  = 9'h020, C_WR  = 9'h040, C_PRE = 9'h080, C_BAD = 9'h100
	} ddrbk_cmd_e;

	// Device bank states
	typedef enum logic [7:0] {
		B_IDLE = 8'h01, B_OPENING = 8'h02, B_ACTIVE = 8'h04, B_READ = 8'h08,
		B_WRITE = 8'h10, B_PRECH = 8'h20, B_RD_AP = 8'h40, B_WR_AP = 8'h80
	} ddrbk_bank_e;

	// Controller user operations
	typedef enum logic [6:0] {
		OP_ACT = 7'h01, OP_RD = 7'h02, OP_WR = 7'h04, OP_PRE = 7'h08,
		OP_PREA = 7'h10, OP_REF = 7'h20, OP_LMR = 7'h40
	} ddrbk_op_e;

	// Controller bank view
	typedef enum logic [4:0] {
		K_IDLE = 5'h01, K_OPENING = 5'h02, K_OPEN = 5'h04, K_BURST = 5'h08, K_CLOSING = 5'h10
	} ddrbk_kst_e;
endpackage
